// ===== inc/hsc_consts.svh
// Constants of the hot standby change-over controller: register offsets,
// field positions, reset values and timing counts.
// Assumes a 100 MHz clock and a 32-bit Avalon-MM slave with byte addresses.
//
// Overview of operation
// [R1] Standby side never drives field control
// [R2] Exactly one side is primary
// [R3] Primary power loss hands over control
// [R4] Host swap command exchanges the roles
// [R5] Operator selection makes that side primary
// [R6] Enabled connector removal causes change-over
// [R7] Enabled Modbus TCP halt causes change-over
// [R8] Enabled Modbus RTU halt causes change-over
// [R9] Button held 3 s enters forced mode
// [R10] Forced mode ignores all other triggers
// [R11] Button indicator blinks during forced mode
// [R12] Button held 3 s again leaves forced
// [R13] Shared Ethernet setting, separate serial settings
// [R14] Active port replies in both roles
// [R15] Passive port replies only when primary
// [R16] Active standby executes only switch command
// [R17] Passive standby executes serial switch only
// [R18] Primary replies and executes every command
// [R19] Host sends operation commands to primary
// [R20] Termination enables off, one per port
// [R21] Role swap is one atomic step
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

// Register byte offsets
`define HSC_CTRL_OFS      4'h0
`define HSC_MODE_OFS      4'h4
`define HSC_TERM_OFS      4'h8
`define HSC_STATUS_OFS    4'hc

// Control register: trigger enables
`define HSC_CTRL_LINK_EN  0
`define HSC_CTRL_TCP_EN   1
`define HSC_CTRL_RTU_EN   2
`define HSC_CTRL_RESET    3'h0

// Standby mode register (1 = Active, 0 = Passive)
`define HSC_MODE_ETH      0
`define HSC_MODE_SER1     1
`define HSC_MODE_SER2     2
`define HSC_MODE_RESET    3'h0

// Termination register
`define HSC_TERM_SER1     0
`define HSC_TERM_SER2     1
`define HSC_TERM_RESET    2'h0

// Status register
`define HSC_STAT_PRIMARY  0
`define HSC_STAT_FORCED   1
`define HSC_STAT_SIDE_B   2

// Timing
`define HSC_CLK_HZ        100000000
`define HSC_HOLD_MS       3000
`define HSC_HOLD_CYC      ((`HSC_CLK_HZ / 1000) * `HSC_HOLD_MS)
`define HSC_BLINK_MS      250
`define HSC_BLINK_CYC     ((`HSC_CLK_HZ / 1000) * `HSC_BLINK_MS)

`endif

// ===== inc/hsc_pkg.sv
// Types of the hot standby change-over controller.
// Assumes the constants header is compiled alongside.
package hsc_pkg;

    typedef enum logic [1:0] {
        HSC_ST_STANDBY = 2'b00,
        HSC_ST_PRIMARY = 2'b01,
        HSC_ST_FORCED  = 2'b10
    } hsc_role_t;

    typedef enum logic [0:0] {
        HSC_PASSIVE = 1'b0,
        HSC_ACTIVE  = 1'b1
    } hsc_sby_mode_t;

endpackage : hsc_pkg

// ===== core/hsc_changeover.sv
// Change-over controller of one side of a hot standby station.
// Assumes the peer side, host ports and button reach it as pins; all
// pin inputs except op_select_primary are synchronised here. Host commands arrive as pulses.
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "hsc_consts.svh"

module hsc_changeover #(
    parameter int unsigned HOLD_CYC  = `HSC_HOLD_CYC,
    parameter int unsigned BLINK_CYC = `HSC_BLINK_CYC,
    parameter logic        SIDE_B    = 1'b0
) (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 reset,
    // Avalon-MM slave
    input  wire logic [3:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // Peer side and power
    input  wire logic                 peer_is_primary,
    input  wire logic                 peer_power_lost,
    input  wire logic                 own_power_fail,
    // Operator
    input  wire logic                 button_n,
    input  wire logic                 op_select_primary,
    output logic                      button_led,
    // Host link health (pins)
    input  wire logic [1:0]           eth_link_up,
    input  wire logic [1:0]           tcp_traffic_ok,
    input  wire logic [1:0]           rtu_traffic_ok,
    // Host commands, one-cycle pulses from on-chip protocol logic
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_is_switch,
    input  wire logic                 cmd_is_become_standby,
    input  wire logic [1:0]           cmd_port,
    output logic                      cmd_reply_en,
    output logic                      cmd_execute,
    // Role and field control
    output logic                      is_primary,
    output logic                      field_ctrl_en,
    output logic                      swap_request,
    // RS-485 termination
    output logic [1:0]                term_en
);
    import hsc_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    wire  [NSYNC-1:0] raw_in = {rtu_traffic_ok, tcp_traffic_ok, eth_link_up,
                                ~button_n, own_power_fail, peer_power_lost,
                                peer_is_primary};

    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    wire       s_peer_primary = sync2_ff[0];
    wire       s_peer_lost    = sync2_ff[1];
    wire       s_own_fail     = sync2_ff[2];
    wire       s_button       = sync2_ff[3];
    wire [1:0] s_link         = sync2_ff[5:4];
    wire [1:0] s_tcp          = sync2_ff[7:6];
    wire [1:0] s_rtu          = sync2_ff[9:8];

    // ------------------------------------------------------------
    // Registers and bus slave
    // ------------------------------------------------------------
    logic [2:0] ctrl_ff;
    logic [2:0] mode_ff;
    logic [1:0] term_ff;
    logic       sw_swap_ff;
    logic       rd_done_ff;
    logic [31:0] rdata_ff;

    wire sel_ctrl = avs_address == `HSC_CTRL_OFS;
    wire sel_mode = avs_address == `HSC_MODE_OFS;
    wire sel_term = avs_address == `HSC_TERM_OFS;
    wire sel_stat = avs_address == `HSC_STATUS_OFS;
    wire wr_ok    = avs_write;
    // Reads take one wait cycle so read data come from a flop
    assign avs_waitrequest = avs_read & ~rd_done_ff;
    assign avs_readdata    = rdata_ff;

    hsc_role_t role_ff;
    hsc_role_t nxt_role;

    wire [31:0] rd_mux =
        sel_ctrl ? {29'h0, ctrl_ff} :
        sel_mode ? {29'h0, mode_ff} :
        sel_term ? {30'h0, term_ff} :
        sel_stat ? {29'h0, SIDE_B, role_ff == HSC_ST_FORCED, role_ff != HSC_ST_STANDBY} :
        32'h0;

    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_ff    <= `HSC_CTRL_RESET;
            mode_ff    <= `HSC_MODE_RESET;
            // [R20] Termination off reset
            term_ff    <= `HSC_TERM_RESET;
            sw_swap_ff <= 1'b0;
            rd_done_ff <= 1'b0;
            rdata_ff   <= 32'h0;
        end else begin
            rd_done_ff <= avs_read & ~rd_done_ff;
            rdata_ff   <= rd_mux;
            // Writing 1 to status bit 0 is a local operator primary select
            sw_swap_ff <= wr_ok & sel_stat & avs_writedata[`HSC_STAT_PRIMARY];
            if (wr_ok && sel_ctrl) ctrl_ff <= avs_writedata[2:0];
            // [R13] Shared and separate modes
            if (wr_ok && sel_mode) mode_ff <= avs_writedata[2:0];
            // [R20] Independent port enables
            if (wr_ok && sel_term) term_ff <= avs_writedata[1:0];
        end
    end
    assign term_en = term_ff;

    // ------------------------------------------------------------
    // Button hold timer
    // ------------------------------------------------------------
    logic [31:0] hold_ff;
    logic        hold_fired_ff;
    // [R9] Three second hold
    wire hold_done = s_button && !hold_fired_ff && hold_ff == HOLD_CYC - 1;

    always_ff @(posedge clock) begin
        if (reset) begin
            hold_ff       <= 32'h0;
            hold_fired_ff <= 1'b0;
        end else if (!s_button) begin
            hold_ff       <= 32'h0;
            hold_fired_ff <= 1'b0;
        end else if (!hold_fired_ff) begin
            hold_ff       <= hold_ff + 32'h1;
            hold_fired_ff <= hold_done;
        end
    end

    // Short press: button released before the hold expired
    logic btn_prev_ff;
    always_ff @(posedge clock) begin
        if (reset) btn_prev_ff <= 1'b0;
        else       btn_prev_ff <= s_button;
    end
    wire btn_short = btn_prev_ff && !s_button && !hold_fired_ff;

    // ------------------------------------------------------------
    // Change-over triggers
    // ------------------------------------------------------------
    wire primary = role_ff != HSC_ST_STANDBY;

    // [R6] Connector removal
    wire trig_link = ctrl_ff[`HSC_CTRL_LINK_EN] && (s_link != 2'b11);
    // [R7] TCP traffic halt
    wire trig_tcp  = ctrl_ff[`HSC_CTRL_TCP_EN]  && (s_tcp  != 2'b11);
    // [R8] RTU traffic halt
    wire trig_rtu  = ctrl_ff[`HSC_CTRL_RTU_EN]  && (s_rtu  != 2'b11);
    wire health_bad = trig_link | trig_tcp | trig_rtu | s_own_fail;

    // Port 0/1 Ethernet, 2/3 serial 1/2
    wire port_serial = cmd_port[1];
    wire port_active = port_serial ? mode_ff[cmd_port[0] ? `HSC_MODE_SER2 : `HSC_MODE_SER1]
                                   : mode_ff[`HSC_MODE_ETH];

    // [R14] [R15] Reply gating by mode
    assign cmd_reply_en = cmd_valid && (primary || port_active);
    // [R18] Primary executes all
    wire exec_primary = cmd_valid && primary;
    // [R16] Active standby only switch
    wire exec_sby_act = cmd_valid && !primary && port_active && cmd_is_switch;
    // [R17] Passive standby serial switch
    wire exec_sby_pas = cmd_valid && !primary && !port_active && port_serial && cmd_is_switch;
    assign cmd_execute = exec_primary | exec_sby_act | exec_sby_pas;

    // [R4] Host swap command
    wire host_swap = cmd_execute && (cmd_is_switch || (primary && cmd_is_become_standby));
    // [R5] Operator selects this side
    wire op_sel = op_select_primary || sw_swap_ff || btn_short;

    // ------------------------------------------------------------
    // Role state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_role = role_ff;
        unique case (role_ff)
            HSC_ST_STANDBY: begin
                // [R3] Peer power loss
                if (hold_done && !s_peer_primary) nxt_role = HSC_ST_FORCED;
                else if (!s_own_fail && (s_peer_lost || host_swap || op_sel)) nxt_role = HSC_ST_PRIMARY;
                // A failing or unhealthy side must not grab control back, or it would oscillate
                else if (!s_peer_primary && !s_peer_lost && !health_bad)
                    nxt_role = SIDE_B ? HSC_ST_STANDBY : HSC_ST_PRIMARY;
            end
            HSC_ST_PRIMARY: begin
                if (hold_done) nxt_role = HSC_ST_FORCED;
                else if (host_swap || health_bad) nxt_role = HSC_ST_STANDBY;
            end
            HSC_ST_FORCED: begin
                // [R10] Others ignored
                // [R12] Hold again leaves
                if (hold_done) nxt_role = HSC_ST_PRIMARY;
            end
            default: nxt_role = HSC_ST_STANDBY;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) role_ff <= HSC_ST_STANDBY;
        // [R21] Single-step swap
        else       role_ff <= nxt_role;
    end

    // [R2] One primary: the automatic claim waits, and forced entry from standby is refused, while peer holds control
    assign is_primary    = primary;
    // [R1] Standby never controls
    assign field_ctrl_en = primary && !s_own_fail;
    assign swap_request  = primary && (nxt_role == HSC_ST_STANDBY);

    // ------------------------------------------------------------
    // Indicator blink
    // ------------------------------------------------------------
    logic [31:0] blink_ff;
    logic        led_ff;
    always_ff @(posedge clock) begin
        if (reset) begin
            blink_ff <= 32'h0;
            led_ff   <= 1'b0;
        end else if (role_ff == HSC_ST_FORCED) begin
            // [R11] Blink while forced
            blink_ff <= (blink_ff == BLINK_CYC - 1) ? 32'h0 : blink_ff + 32'h1;
            if (blink_ff == BLINK_CYC - 1) led_ff <= ~led_ff;
        end else begin
            blink_ff <= 32'h0;
            led_ff   <= primary;
        end
    end
    assign button_led = led_ff;

endmodule : hsc_changeover
`default_nettype wire

// ===== verification/hsc_properties.sv
// Port checker of the change-over controller.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module hsc_properties (
    // Clock, reset and causes
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       own_power_fail,
    input wire logic       op_select_primary,
    input wire logic       cmd_valid,
    input wire logic       cmd_is_switch,
    input wire logic       cmd_is_become_standby,
    // Watched outputs
    input wire logic       cmd_reply_en,
    input wire logic       cmd_execute,
    input wire logic       is_primary,
    input wire logic       field_ctrl_en,
    input wire logic       swap_request,
    input wire logic [1:0] term_en
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    property p_field_pri; field_ctrl_en |-> is_primary; endproperty
    a_field_pri: assert property (p_field_pri)
        else $error("field control while standby");
    property p_term_off; $fell(reset) |-> term_en == 2'h0; endproperty
    a_term_off: assert property (p_term_off)
        else $error("termination on after reset");
    property p_swap; swap_request |=> !is_primary; endproperty
    a_swap: assert property (p_swap)
        else $error("swap request without leaving primary");
    property p_leave; $fell(is_primary) |-> $past(swap_request); endproperty
    a_leave: assert property (p_leave)
        else $error("primary left without swap request");
    property p_pri_cmd;
        cmd_valid && is_primary && !cmd_is_switch && !cmd_is_become_standby |-> cmd_reply_en && cmd_execute;
    endproperty
    a_pri_cmd: assert property (p_pri_cmd)
        else $error("primary did not serve command");
    property p_sby_exec; cmd_execute && !is_primary |-> cmd_valid && cmd_is_switch; endproperty
    a_sby_exec: assert property (p_sby_exec)
        else $error("standby executed non-switch command");
    property p_power; $rose(own_power_fail) |-> ##[1:6] !field_ctrl_en; endproperty
    a_power: assert property (p_power)
        else $error("failing side kept field control");
    property p_select; op_select_primary |-> ##[1:3] is_primary; endproperty
    a_select: assert property (p_select)
        else $error("operator selection ignored");
    c_sby_switch: cover property (cmd_execute && !is_primary);
    c_swap: cover property (swap_request);
    c_silent: cover property (cmd_valid && !cmd_reply_en);
endmodule : hsc_properties
bind hsc_changeover hsc_properties hsc_properties_i (.clock(clock), .reset(reset),
    .own_power_fail(own_power_fail), .op_select_primary(op_select_primary), .cmd_valid(cmd_valid),
    .cmd_is_switch(cmd_is_switch), .cmd_is_become_standby(cmd_is_become_standby),
    .cmd_reply_en(cmd_reply_en), .cmd_execute(cmd_execute), .is_primary(is_primary),
    .field_ctrl_en(field_ctrl_en), .swap_request(swap_request), .term_en(term_en));
`default_nettype wire

// ===== verification/hsc_host_model.sv
// Host model: sends host commands to one side as one-cycle pulses.
// Assumes its task is entered at a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module hsc_host_model (
    // Clock
    input wire logic  clock,
    // Command pulse
    output logic       cmd_valid,
    output logic       cmd_is_switch,
    output logic       cmd_is_become_standby,
    output logic [1:0] cmd_port,
    // Answer
    input wire logic  cmd_reply_en,
    input wire logic  cmd_execute
);
    initial begin
        cmd_valid = 1'b0;
        cmd_is_switch = 1'b0;
        cmd_is_become_standby = 1'b0;
        cmd_port = 2'h0;
    end
    task automatic send(input logic sw, input logic [1:0] port, output logic rep, output logic exe);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_is_switch <= sw;
        cmd_port <= port;
        @(posedge clock);
        rep = cmd_reply_en;
        exe = cmd_execute;
        cmd_valid <= 1'b0;
        // Qualifiers turn to junk so a design reading them idle is caught
        cmd_is_switch <= ~sw;
        cmd_port <= ~port;
    endtask : send
endmodule : hsc_host_model
`default_nettype wire

// ===== verification/hsc_changeover_tb.sv
// Bench of the change-over controller as side A with short counts.
// Assumes the host model for commands; bus and pins are driven here.
`timescale 1ns/1ps
`default_nettype none
module hsc_changeover_tb;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_address = 4'h0;
    logic [1:0]  eth_ok = 2'h3, tcp_ok = 2'h3, rtu_ok = 2'h3, term_en, cmd_port;
    logic        clock = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic        peer_pri = 1'b0, pwr_fail = 1'b0, button_n = 1'b1, op_sel = 1'b0, button_led;
    logic        peer_lost = 1'b0;
    logic        cmd_valid, cmd_sw, cmd_sb, cmd_reply_en, cmd_execute, is_primary, field_ctrl_en, rep, exe;
    int          miscompares = 0, checks_done = 0, cycles = 0;

    hsc_changeover #(.HOLD_CYC(20), .BLINK_CYC(4)) hsc_changeover_i (.clock(clock), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .peer_is_primary(peer_pri), .peer_power_lost(peer_lost), .own_power_fail(pwr_fail),
        .button_n(button_n), .op_select_primary(op_sel), .button_led(button_led),
        .eth_link_up(eth_ok), .tcp_traffic_ok(tcp_ok), .rtu_traffic_ok(rtu_ok), .cmd_valid(cmd_valid),
        .cmd_is_switch(cmd_sw), .cmd_is_become_standby(cmd_sb), .cmd_port(cmd_port),
        .cmd_reply_en(cmd_reply_en), .cmd_execute(cmd_execute), .is_primary(is_primary),
        .field_ctrl_en(field_ctrl_en), .swap_request(), .term_en(term_en));
    hsc_host_model hsc_host_model_i (.clock(clock), .cmd_valid(cmd_valid), .cmd_is_switch(cmd_sw),
        .cmd_is_become_standby(cmd_sb), .cmd_port(cmd_port), .cmd_reply_en(cmd_reply_en),
        .cmd_execute(cmd_execute));

    initial begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest) @(posedge clock);
        avs_write <= 1'b0;
    endtask : av_wr
    task automatic av_rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge clock);
        while (avs_waitrequest) @(posedge clock);
        chk("readdata", exp, avs_readdata);
        avs_read <= 1'b0;
    endtask : av_rd
    task automatic cmd(input logic sw, input logic [1:0] port, input logic er, input logic ee);
        hsc_host_model_i.send(sw, port, rep, exe);
        if (!sw) chk("cmd_reply_en", er, rep);
        chk("cmd_execute", ee, exe);
    endtask : cmd
    task automatic wait_role(input logic exp);
        for (int i = 0; i < 30 && is_primary !== exp; i++) @(posedge clock);
        chk("is_primary", exp, is_primary);
    endtask : wait_role
    task automatic health(input int t);
        eth_ok <= (t == 0) ? 2'h1 : 2'h3;
        tcp_ok <= (t == 1) ? 2'h2 : 2'h3;
        rtu_ok <= (t == 2) ? 2'h1 : 2'h3;
    endtask : health
    task automatic pulse_sel;
        @(posedge clock);
        op_sel <= 1'b1;
        @(posedge clock);
        op_sel <= 1'b0;
    endtask : pulse_sel
    task automatic hold;
        @(posedge clock);
        button_n <= 1'b0;
        repeat (30) @(posedge clock);
        button_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : hold
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        wait_role(1'b1);
        for (int a = 0; a < 12; a += 4) av_rd(a[3:0], 32'h0);
        av_rd(4'h2, 32'h0);
        av_wr(4'h8, 32'h2);
        av_rd(4'h8, 32'h2);
        chk("term_en", 32'h2, {30'h0, term_en});
        cmd(1'b0, 2'h0, 1'b1, 1'b1);
        // Peer must be seen as primary before the swap, else side A takes control back
        peer_pri <= 1'b1;
        repeat (4) @(posedge clock);
        cmd(1'b1, 2'h0, 1'b1, 1'b1);
        wait_role(1'b0);
        chk("field_ctrl_en", 32'h0, {31'h0, field_ctrl_en});
        cmd(1'b0, 2'h0, 1'b0, 1'b0);
        cmd(1'b1, 2'h0, 1'b0, 1'b0);
        av_wr(4'h4, 32'h1);
        cmd(1'b0, 2'h1, 1'b1, 1'b0);
        cmd(1'b0, 2'h2, 1'b0, 1'b0);
        cmd(1'b1, 2'h2, 1'b0, 1'b1);
        peer_pri <= 1'b0;
        wait_role(1'b1);
        pwr_fail <= 1'b1;
        wait_role(1'b0);
        pwr_fail <= 1'b0;
        pulse_sel();
        wait_role(1'b1);
        for (int t = 0; t < 3; t++) begin
            health(t);
            repeat (10) @(posedge clock);
            chk("is_primary", 32'h1, {31'h0, is_primary});
            av_wr(4'h0, 32'h1 << t);
            wait_role(1'b0);
            health(3);
            av_wr(4'h0, 32'h0);
            pulse_sel();
            wait_role(1'b1);
        end
        hold();
        av_rd(4'hc, 32'h3);
        rep = button_led;
        repeat (4) @(posedge clock);
        chk("button_led", {31'h0, !rep}, {31'h0, button_led});
        cmd(1'b1, 2'h0, 1'b1, 1'b1);
        repeat (4) @(posedge clock);
        chk("is_primary", 32'h1, {31'h0, is_primary});
        av_wr(4'h0, 32'h1);
        health(0);
        repeat (10) @(posedge clock);
        chk("is_primary", 32'h1, {31'h0, is_primary});
        health(3);
        av_wr(4'h0, 32'h0);
        hold();
        av_rd(4'hc, 32'h1);
        peer_pri <= 1'b1;
        repeat (4) @(posedge clock);
        cmd(1'b1, 2'h0, 1'b1, 1'b1);
        wait_role(1'b0);
        peer_lost <= 1'b1;
        wait_role(1'b1);
        end_sim();
    end
endmodule : hsc_changeover_tb
`default_nettype wire
